// File: pkg/udt_pkg.sv
// udt_pkg: constants and carrier types for the up/down reload timer.
// assumes a single 50 MHz peripheral clock and synchronous reset.
package udt_pkg;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int UDT_CLK_MHZ = 50;
   localparam logic [3:0] UDT_TIMER_DIV = 4'hC;
   localparam logic [3:0] UDT_DIV_LAST = 4'hB;
   // -----------------------------------------------------------------
   // values
   // -----------------------------------------------------------------
   localparam logic [15:0] UDT_COUNT_MAX = 16'hFFFF;
   localparam logic [7:0] UDT_BYTE_RST = 8'h00;
   localparam logic [7:0] UDT_BYTE_MAX = 8'hFF;
   // control byte field positions
   localparam int UDT_B_OVF = 7;
   localparam int UDT_B_EXT = 6;
   localparam int UDT_B_RCLK = 5;
   localparam int UDT_B_TX_CLOCK_FROM_TIMER = 4;
   localparam int UDT_B_EXEN = 3;
   localparam int UDT_B_RUN = 2;
   localparam int UDT_B_SRC = 1;
   localparam int UDT_B_CAP = 0;

   typedef struct packed {
      logic rx_clock_from_timer;
      logic tx_clock_from_timer;
      logic ext_trigger_enable;
      logic run_control;
      logic count_source_select;
      logic capture_reload_select;
      logic clockout_enable;
      logic updown_enable;
   } udt_cfg_t;

   typedef struct packed {
      logic wr_low;
      logic wr_high;
      logic wr_rld_low;
      logic wr_rld_high;
      logic clr_overflow;
      logic clr_external;
      logic [7:0] data;
   } udt_wr_t;

   typedef enum logic [1:0] {
      UDT_MODE_CAPTURE,
      UDT_MODE_RELOAD,
      UDT_MODE_BAUD
   } udt_mode_t;
endpackage

// File: verilog/udt_timer.sv
// udt_timer: 16-bit timer with capture, reload, up/down, baud, clock-out.
// assumes control bits and byte writes come from same-clock logic; the
// count pin and trigger pin are asynchronous and are synchronised here.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - count is low byte cascaded into high byte
// - source: clock divided by 12, or pin edges
// - low byte advances only while run set
// - capture, reload, baud modes from select bits
// - up/down enable lets trigger pin pick direction
// - up: overflow sets flag, loads reload pair
// - down: equal reload underflows, loads FFFFh
// - up/down toggles external flag, no interrupt
// - clock-out counts at half clock, square wave
// - clock-out overflow reloads, no interrupt
// - output frequency clock over 4*(65536-reload)
// - clock-out drives count pin as output
// - baud and clock-out share reload pair
// - overflow flag only without serial clocks, sticky
// - capture on trigger fall sets external flag
// - serial clocks force auto-reload
// - plain reload also on trigger fall
module udt_timer (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire udt_pkg::udt_cfg_t i_cfg,
   input wire udt_pkg::udt_wr_t i_wr,
   input wire logic i_count_pin,
   input wire logic i_ext_trigger_pin,
   output logic o_count_pin,
   output logic o_count_pin_oe,
   output logic [7:0] o_count_low_byte,
   output logic [7:0] o_count_high_byte,
   output logic [7:0] o_reload_low_byte,
   output logic [7:0] o_reload_high_byte,
   output logic o_overflow_flag,
   output logic o_external_flag,
   output logic o_irq,
   output logic o_baud_tick
);
   import udt_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [15:0] count_r, count_nxt;
   logic [15:0] reload_r, reload_nxt;
   logic ovf_r, ovf_nxt;
   logic ext_r, ext_nxt;
   logic [3:0] div_r, div_nxt;
   logic half_r, half_nxt;
   logic clk_out_r, clk_out_nxt;
   logic baud_r, baud_nxt;
   logic pin_s1_r, pin_s2_r, pin_s3_r;
   logic trg_s1_r, trg_s2_r, trg_s3_r;
   udt_mode_t mode;

   function automatic udt_mode_t sel_mode(input udt_cfg_t c);
      if (c.rx_clock_from_timer || c.tx_clock_from_timer) begin
         sel_mode = UDT_MODE_BAUD;
      end else if (c.capture_reload_select) begin
         sel_mode = UDT_MODE_CAPTURE;
      end else begin
         sel_mode = UDT_MODE_RELOAD;
      end
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // third stage only feeds edge detection, never the first stage
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
         pin_s3_r <= 1'b1;
         trg_s1_r <= 1'b1;
         trg_s2_r <= 1'b1;
         trg_s3_r <= 1'b1;
      end else begin
         pin_s1_r <= i_count_pin;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         trg_s1_r <= i_ext_trigger_pin;
         trg_s2_r <= trg_s1_r;
         trg_s3_r <= trg_s2_r;
      end
   end

   // ----------------------------------------------------------------
   // counter logic
   // ----------------------------------------------------------------
   always_comb begin
      logic tick;
      logic trg_fall;
      logic up;
      logic wrap;
      logic dn_hit;
      logic ev;
      logic ovf_set;
      logic ext_hit;
      tick = 1'b0;
      ovf_set = 1'b0;
      ext_hit = 1'b0;
      trg_fall = trg_s3_r & ~trg_s2_r;
      up = 1'b1;
      wrap = 1'b0;
      dn_hit = 1'b0;
      ev = 1'b0;
      mode = sel_mode(i_cfg);
      count_nxt = count_r;
      reload_nxt = reload_r;
      ovf_nxt = ovf_r;
      ext_nxt = ext_r;
      div_nxt = div_r;
      half_nxt = half_r;
      clk_out_nxt = clk_out_r;
      baud_nxt = 1'b0;
      // clock-out uses a two-cycle prescale instead of divide by 12
      if (i_cfg.clockout_enable && !i_cfg.count_source_select) begin
         half_nxt = ~half_r;
         tick = half_r;
      end else if (i_cfg.count_source_select) begin
         tick = pin_s3_r & ~pin_s2_r;
      end else begin
         div_nxt = (div_r == UDT_DIV_LAST) ? 4'h0 : div_r + 4'h1;
         tick = (div_r == UDT_DIV_LAST);
      end
      if (!i_cfg.run_control) begin
         tick = 1'b0;
      end
      if (i_cfg.updown_enable && mode == UDT_MODE_RELOAD) begin
         up = trg_s2_r;
      end
      if (tick) begin
         if (up) begin
            wrap = (count_r == UDT_COUNT_MAX);
            // low byte carries into high byte
            count_nxt = count_r + 16'h0001;
            if (wrap) begin
               count_nxt = reload_r;
            end
         end else begin
            dn_hit = (count_r == reload_r);
            count_nxt = dn_hit ? UDT_COUNT_MAX : count_r - 16'h0001;
         end
         ev = wrap | dn_hit;
      end
      if (ev) begin
         if (mode != UDT_MODE_BAUD && !i_cfg.clockout_enable) begin
            ovf_nxt = 1'b1;
            ovf_set = 1'b1;
         end
         if (mode == UDT_MODE_BAUD) begin
            baud_nxt = 1'b1;
         end
         if (i_cfg.clockout_enable) begin
            clk_out_nxt = ~clk_out_r;
         end
         if (i_cfg.updown_enable && mode == UDT_MODE_RELOAD) begin
            ext_nxt = ~ext_r;
            ext_hit = 1'b1;
         end
      end
      if (trg_fall && i_cfg.ext_trigger_enable) begin
         if (mode == UDT_MODE_CAPTURE) begin
            reload_nxt = count_r;
            ext_nxt = 1'b1;
            ext_hit = 1'b1;
         end else if (mode == UDT_MODE_RELOAD && !i_cfg.updown_enable) begin
            count_nxt = reload_r;
            ext_nxt = 1'b1;
            ext_hit = 1'b1;
         end
      end
      // software writes; a hardware set in the same cycle beats a clear
      if (i_wr.clr_overflow && !ovf_set) begin
         ovf_nxt = 1'b0;
      end
      if (i_wr.clr_external && !ext_hit) begin
         ext_nxt = 1'b0;
      end
      if (i_wr.wr_low) begin
         count_nxt[7:0] = i_wr.data;
      end
      if (i_wr.wr_high) begin
         count_nxt[15:8] = i_wr.data;
      end
      if (i_wr.wr_rld_low) begin
         reload_nxt[7:0] = i_wr.data;
      end
      if (i_wr.wr_rld_high) begin
         reload_nxt[15:8] = i_wr.data;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         count_r <= 16'h0000;
         reload_r <= 16'h0000;
         ovf_r <= 1'b0;
         ext_r <= 1'b0;
         div_r <= 4'h0;
         half_r <= 1'b0;
         clk_out_r <= 1'b1;
         baud_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         reload_r <= reload_nxt;
         ovf_r <= ovf_nxt;
         ext_r <= ext_nxt;
         div_r <= div_nxt;
         half_r <= half_nxt;
         clk_out_r <= clk_out_nxt;
         baud_r <= baud_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // interrupt from external flag is masked in up/down mode
   logic irq_r;
   logic oe_r;
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         irq_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         irq_r <= ovf_nxt | (ext_nxt & ~i_cfg.updown_enable);
         oe_r <= i_cfg.clockout_enable & ~i_cfg.count_source_select;
      end
   end

   assign o_count_pin = clk_out_r;
   assign o_count_pin_oe = oe_r;
   assign o_count_low_byte = count_r[7:0];
   assign o_count_high_byte = count_r[15:8];
   assign o_reload_low_byte = reload_r[7:0];
   assign o_reload_high_byte = reload_r[15:8];
   assign o_overflow_flag = ovf_r;
   assign o_external_flag = ext_r;
   assign o_irq = irq_r;
   assign o_baud_tick = baud_r;
endmodule

`default_nettype wire

// File: testbench/udt_pins.sv
// udt_pins: far-side model driving the count pin and trigger/direction pin.
// assumes pins change at the falling clock edge, like the bench inputs.
`timescale 1ns/10ps
`default_nettype none
module udt_pins (
   input wire logic i_clock,
   output logic o_count,
   output logic o_trigger
);
   import udt_pkg::*;
   // idle high, so only commanded pulses or direction changes give falling edges
   initial begin
      o_count = 1'h1;
      o_trigger = 1'h1;
   end
   // four cycles per level, well above the input synchroniser delay
   task automatic pulse(input int k);
      repeat (k) begin
         @(negedge i_clock);
         o_count = 1'h0;
         repeat (4) @(negedge i_clock);
         o_count = 1'h1;
         repeat (4) @(negedge i_clock);
      end
   endtask
   task automatic set_dir(input logic up);
      @(negedge i_clock);
      o_trigger = up;
   endtask
endmodule
`default_nettype wire

// File: testbench/udt_timer_assertions.sv
// udt_timer_checker: port-level properties of the reload timer.
// assumes it is bound to udt_timer and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module udt_timer_checker (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire udt_pkg::udt_cfg_t i_cfg,
   input wire udt_pkg::udt_wr_t i_wr,
   input wire logic o_count_pin_oe,
   input wire logic [7:0] o_count_low_byte,
   input wire logic [7:0] o_count_high_byte,
   input wire logic o_overflow_flag,
   input wire logic o_external_flag,
   input wire logic o_irq
);
   import udt_pkg::*;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   hold_count_a: assert property (
      !i_cfg.run_control && !i_cfg.ext_trigger_enable && !i_wr.wr_low &&
      !i_wr.wr_high |=> $stable({o_count_high_byte, o_count_low_byte}))
      else $error("count moved while stopped");
   write_low_a: assert property (
      i_wr.wr_low |=> o_count_low_byte == $past(i_wr.data))
      else $error("low byte write lost");
   ovf_sticky_a: assert property (
      o_overflow_flag && !i_wr.clr_overflow |=> o_overflow_flag)
      else $error("overflow flag dropped");
   ovf_serial_a: assert property (
      $rose(o_overflow_flag) |-> !$past(i_cfg.rx_clock_from_timer) &&
      !$past(i_cfg.tx_clock_from_timer))
      else $error("overflow flag set in baud mode");
   irq_cause_a: assert property (
      o_irq == (o_overflow_flag ||
      (o_external_flag && !$past(i_cfg.updown_enable))))
      else $error("irq not matching flags");
   // a change from a wrap is a tick too, so no exception for reloads
   timer_rate_a: assert property (
      $changed(o_count_low_byte) && i_cfg.run_control &&
      !i_cfg.count_source_select && !i_cfg.clockout_enable &&
      !i_cfg.ext_trigger_enable |=> $stable(o_count_low_byte)[*8])
      else $error("timer ticks faster than divide by 12");
   clockout_step_a: assert property (
      $changed(o_count_low_byte) && i_cfg.run_control &&
      i_cfg.clockout_enable |=> $stable(o_count_low_byte) ##1
      ($changed(o_count_low_byte) || !i_cfg.run_control))
      else $error("clock-out count not every 2 clocks");
   pin_enable_a: assert property (
      1'h1 |=> o_count_pin_oe == ($past(i_cfg.clockout_enable) &&
      !$past(i_cfg.count_source_select)))
      else $error("count pin enable wrong");
endmodule
bind udt_timer udt_timer_checker chk_i (.i_clock(i_clock), .i_rst(i_rst),
   .i_cfg(i_cfg), .i_wr(i_wr), .o_count_pin_oe(o_count_pin_oe),
   .o_count_low_byte(o_count_low_byte), .o_irq(o_irq),
   .o_count_high_byte(o_count_high_byte), .o_overflow_flag(o_overflow_flag),
   .o_external_flag(o_external_flag));
`default_nettype wire

// File: testbench/tb.sv
// tb: self-checking bench for the up/down reload timer.
// assumes udt_pins drives the pins and the checker is bound to the dut.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import udt_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   udt_cfg_t cfg = '0;
   udt_wr_t wr = '0;
   logic cpin, oe, cnt_in, trig, ovf, ext, irq, baud;
   logic [7:0] cl, ch, rl, rh;
   int miscompares = 0, checked = 0, cyc = 0, n = 0, t = 0;
   // the count pin wire: dut drives it in clock-out, else the far side
   wire logic pin_w = oe ? cpin : cnt_in;
   initial forever #10 clk = ~clk;
   udt_pins pins (.i_clock(clk), .o_count(cnt_in), .o_trigger(trig));
   udt_timer dut (.i_clock(clk), .i_rst(rst), .i_cfg(cfg), .i_wr(wr),
      .i_count_pin(pin_w), .i_ext_trigger_pin(trig), .o_count_pin(cpin),
      .o_count_pin_oe(oe), .o_count_low_byte(cl), .o_count_high_byte(ch),
      .o_reload_low_byte(rl), .o_reload_high_byte(rh), .o_irq(irq),
      .o_overflow_flag(ovf), .o_external_flag(ext), .o_baud_tick(baud));
   task automatic stop_test;
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one-cycle strobe: 0 low, 1 high, 2/3 reload, 4/5 flag clears
   task automatic put(input int sel, input logic [7:0] d);
      @(negedge clk);
      wr = udt_wr_t'({6'h20 >> sel, d});
      @(negedge clk);
      wr = '0;
   endtask
   task automatic load(input logic [15:0] c, r);
      put(0, c[7:0]);
      put(1, c[15:8]);
      put(2, r[7:0]);
      put(3, r[15:8]);
   endtask
   task automatic till(ref logic s, input logic v);
      n = 0;
      while (s !== v && n < 200) begin
         @(negedge clk);
         n++;
      end
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'h0;
      load(16'hFFFE, 16'h1234);
      chk("count", 16'hFFFE, {ch, cl});
      chk("reload", 16'h1234, {rh, rl});
      cfg.run_control = 1'h1;
      till(ovf, 1'h1);
      chk("reloaded", 16'h1234, {ch, cl});
      chk("irq", 16'h0001, irq);
      repeat (36) @(negedge clk);
      chk("rate", 16'h1237, {ch, cl});
      cfg = '0;
      put(4, 8'h00);
      chk("ovf_clear", 16'h0000, ovf);
      pins.set_dir(1'h0);
      cfg.updown_enable = 1'h1;
      load(16'h1236, 16'h1234);
      cfg.run_control = 1'h1;
      till(ovf, 1'h1);
      chk("underflow", 16'hFFFF, {ch, cl});
      chk("ext_toggle", 16'h0001, ext);
      cfg.run_control = 1'h0;
      put(4, 8'h00);
      chk("irq_ext", 16'h0000, irq);
      cfg = '0;
      put(5, 8'h00);
      pins.set_dir(1'h1);
      cfg.clockout_enable = 1'h1;
      load(16'hFFF0, 16'hFFF0);
      cfg.run_control = 1'h1;
      till(cpin, 1'h0);
      till(cpin, 1'h1);
      t = cyc;
      till(cpin, 1'h0);
      chk("high_half", 16'h0020, 16'(cyc - t));
      till(cpin, 1'h1);
      chk("period", 16'h0040, 16'(cyc - t));
      chk("pin_oe", 16'h0001, oe);
      chk("no_ovf", 16'h0000, ovf);
      cfg = '0;
      cfg.count_source_select = 1'h1;
      load(16'h0010, 16'h0000);
      cfg.run_control = 1'h1;
      pins.pulse(5);
      repeat (6) @(negedge clk);
      chk("events", 16'h0015, {ch, cl});
      cfg = '0;
      cfg.tx_clock_from_timer = 1'h1;
      load(16'hFFFE, 16'h1234);
      cfg.run_control = 1'h1;
      till(baud, 1'h1);
      chk("baud_reload", 16'h1234, {ch, cl});
      chk("baud_no_ovf", 16'h0000, ovf);
      @(negedge clk);
      chk("baud_pulse", 16'h0000, baud);
      cfg = '0;
      cfg.capture_reload_select = 1'h1;
      cfg.ext_trigger_enable = 1'h1;
      load(16'h0042, 16'h0000);
      pins.set_dir(1'h0);
      repeat (4) @(negedge clk);
      chk("capture", 16'h0042, {rh, rl});
      chk("cap_flag", 16'h0001, ext);
      chk("cap_irq", 16'h0001, irq);
      stop_test();
   end
endmodule
`default_nettype wire
